// >>> verilog/swu_cmd.sv
/*
 * command handler for the streaming pio write and mark-uncorrectable commands.
 * assumes a task-file front end that strobes cmd_valid when the host writes
 * the command register, a media engine that takes one sector per handshake,
 * a nonvolatile mark store, and a per-stream configuration table.
 */
`timescale 1ns/1ps
module swu_cmd #(
    parameter int unsigned US_CYCLES = swu_pkg::US_CYCLES  // cycles per microsecond
) (
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    input  wire logic                    cmd_valid,       // host wrote command register
    input  wire swu_pkg::swu_taskfile_s  taskfile,        // registers at that write
    input  wire logic                    hob,             // high-order byte select
    input  wire logic [31:0]             time_unit_us,    // identify words 99:98
    input  wire logic [7:0]              stream_default,  // default limit of selected stream
    input  wire logic                    stream_defined,  // stream ever configured
    input  wire logic [47:0]             stream_err_lba,  // last reported error of stream
    output logic [2:0]                   stream_sel,      // stream whose settings apply
    output logic                         media_valid,     // sector write request
    output swu_pkg::swu_media_req_s      media_req,
    input  wire logic                    media_ready,
    input  wire logic                    media_err,       // with ready: sector failed
    input  wire logic                    media_err_id_not_found,  // failure was id not found
    output logic                         flush_req,       // drain stream buffer
    input  wire logic                    flush_done,
    output logic                         mark_valid,      // nonvolatile mark store request
    output swu_pkg::swu_mark_s           mark,
    input  wire logic                    mark_ready,
    input  wire logic                    mark_fail,       // store could not process
    input  wire logic                    host_write,      // any host sector write seen
    input  wire logic [47:0]             host_write_lba,
    output logic [7:0]                   error_flags,
    output logic [7:0]                   completion_status,
    output logic [7:0]                   lba_low_rd,      // sector number readback
    output logic [7:0]                   lba_mid_rd,      // cylinder low readback
    output logic [7:0]                   lba_high_rd,     // cylinder high readback
    output logic                         done_irq         // completion pulse
);

    // whole state of the handler
    typedef struct packed {
        swu_pkg::swu_state_e state;
        logic [7:0]          feat;
        logic [16:0]         left;       // sectors still to move
        logic [47:0]         lba;        // next sector
        logic [47:0]         fail_lba;   // first unrecoverable
        logic                fail_seen;
        logic                err_any;
        logic                err_id_not_found;
        logic                limited;    // a limit is enforced
        logic [39:0]         limit_us;
        logic [39:0]         used_us;
        logic [31:0]         tick;       // microsecond prescaler
        logic [7:0]          err_q;
        logic [7:0]          stat_q;
        logic                irq;
    } swu_regs_s;

    swu_regs_s r_q, r_d;
    logic [39:0] req_us;     // requested limit before floor
    logic [7:0]  prev_byte;  // chosen previous feature value
    logic        us_tick;    // one-cycle microsecond enable
    logic        expired;
    logic        mu_ok;

    // derive the requested limit; product is wide enough for 8 x 32 bits
    always_comb begin
        prev_byte = (taskfile.feat_prev != 8'h00) ? taskfile.feat_prev : stream_default;
        req_us    = 40'(prev_byte) * 40'(time_unit_us);
    end

    assign us_tick = (r_q.tick == US_CYCLES - 1);
    assign expired = r_q.limited && (r_q.used_us >= r_q.limit_us);
    assign mu_ok   = (taskfile.feat_cur[7:4] == swu_pkg::MU_PSEUDO ||
                      taskfile.feat_cur[7:4] == swu_pkg::MU_FLAGGED) &&
                     (taskfile.feat_cur[3:0] == swu_pkg::MU_LOG ||
                      taskfile.feat_cur[3:0] == swu_pkg::MU_NOLOG);

    // next-state logic
    always_comb begin
        r_d     = r_q;
        r_d.irq = 1'b0;
        // timer counts while busy, from command write to completion
        if (r_q.state != swu_pkg::ST_IDLE && r_q.state != swu_pkg::ST_DONE) begin
            r_d.tick = us_tick ? 32'h0 : r_q.tick + 32'h1;
            if (us_tick && r_q.used_us != 40'hff_ffff_ffff) begin
                r_d.used_us = r_q.used_us + 40'h1;
            end
        end
        case (r_q.state)
            swu_pkg::ST_IDLE: begin
                if (cmd_valid) begin
                    r_d.feat      = taskfile.feat_cur;
                    r_d.lba       = taskfile.lba;
                    r_d.left      = (taskfile.count == 16'h0) ? 17'h1_0000 : {1'b0, taskfile.count};
                    r_d.fail_seen = 1'b0;
                    r_d.err_any   = 1'b0;
                    r_d.err_id_not_found  = 1'b0;
                    r_d.tick      = 32'h0;
                    r_d.used_us   = 40'h0;
                    r_d.limited   = (taskfile.feat_prev != 8'h00) || (stream_defined && stream_default != 8'h00);
                    r_d.limit_us  = (req_us < swu_pkg::LIMIT_FLOOR_US) ? swu_pkg::LIMIT_FLOOR_US : req_us;
                    r_d.err_q     = swu_pkg::ERROR_RST;
                    r_d.stat_q    = 8'h00;
                    r_d.stat_q[swu_pkg::ST_BUSY] = 1'b1;
                    if (taskfile.opcode == swu_pkg::OP_STREAM_WRITE) begin
                        if (taskfile.feat_cur[swu_pkg::FB_RESUME]) begin
                            r_d.lba = stream_err_lba;
                        end
                        r_d.state = swu_pkg::ST_XFER;
                    end else if (taskfile.opcode == swu_pkg::OP_MARK_UNC &&
                                 taskfile.dev_head[swu_pkg::DEVHEAD_LBA] && mu_ok) begin
                        r_d.state = swu_pkg::ST_MARK;
                    end else begin
                        // unknown command, bad feature or lba bit clear in dev_head: abort at once
                        r_d.err_q[swu_pkg::ER_ABORT] = 1'b1;
                        r_d.stat_q = swu_pkg::STATUS_RST;
                        r_d.stat_q[swu_pkg::ST_ERR] = 1'b1;
                        r_d.irq    = 1'b1;
                        r_d.state  = swu_pkg::ST_DONE;
                    end
                end
            end
            swu_pkg::ST_XFER: begin
                if (expired) begin
                    // limit hit: stop where we are
                    r_d.err_q[swu_pkg::ER_TLO] = 1'b1;
                    r_d.stat_q = swu_pkg::STATUS_RST;
                    r_d.stat_q[swu_pkg::ST_STREAM_ERR] = 1'b1;
                    r_d.irq    = 1'b1;
                    r_d.state  = swu_pkg::ST_DONE;
                end else if (media_ready) begin
                    // errors never stop the transfer; the full count is moved
                    if (media_err) begin
                        r_d.err_any  = 1'b1;
                        r_d.err_id_not_found = r_q.err_id_not_found | media_err_id_not_found;
                        if (!r_q.fail_seen) begin
                            r_d.fail_seen = 1'b1;
                            r_d.fail_lba  = r_q.lba;
                        end
                    end
                    r_d.lba  = r_q.lba + 48'h1;
                    r_d.left = r_q.left - 17'h1;
                    if (r_q.left == 17'h1) begin
                        r_d.state = r_q.feat[swu_pkg::FB_FLUSH] ? swu_pkg::ST_FLUSH : swu_pkg::ST_DONE;
                    end
                end
                if (r_d.state == swu_pkg::ST_DONE && !expired) begin
                    r_d.irq    = 1'b1;
                    r_d.stat_q = swu_pkg::STATUS_RST;
                    if (r_d.err_any) begin
                        if (r_q.feat[swu_pkg::FB_CONT_ERR]) begin
                            r_d.stat_q[swu_pkg::ST_STREAM_ERR] = 1'b1;
                        end else begin
                            r_d.stat_q[swu_pkg::ST_ERR] = 1'b1;
                        end
                        r_d.err_q[swu_pkg::ER_ID_NOT_FOUND]  = r_d.err_id_not_found;
                        r_d.err_q[swu_pkg::ER_ABORT] = !r_d.err_id_not_found;
                    end
                end
            end
            swu_pkg::ST_FLUSH: begin
                // completion once the stream buffer is on media, or at once on time limit expiry
                if (expired) begin
                    r_d.err_q[swu_pkg::ER_TLO] = 1'b1;
                    r_d.stat_q = swu_pkg::STATUS_RST;
                    r_d.stat_q[swu_pkg::ST_STREAM_ERR] = 1'b1;
                    r_d.irq    = 1'b1;
                    r_d.state  = swu_pkg::ST_DONE;
                end else if (flush_done) begin
                    r_d.stat_q = swu_pkg::STATUS_RST;
                    if (r_q.err_any) begin
                        r_d.stat_q[r_q.feat[swu_pkg::FB_CONT_ERR] ? swu_pkg::ST_STREAM_ERR : swu_pkg::ST_ERR] = 1'b1;
                        r_d.err_q[swu_pkg::ER_ID_NOT_FOUND]  = r_q.err_id_not_found;
                        r_d.err_q[swu_pkg::ER_ABORT] = !r_q.err_id_not_found;
                    end
                    r_d.irq   = 1'b1;
                    r_d.state = swu_pkg::ST_DONE;
                end
            end
            swu_pkg::ST_MARK: begin
                if (mark_ready) begin
                    r_d.stat_q = swu_pkg::STATUS_RST;
                    if (mark_fail) begin
                        r_d.err_q[swu_pkg::ER_ABORT] = 1'b1;
                        r_d.stat_q[swu_pkg::ST_ERR]  = 1'b1;
                    end
                    r_d.irq   = 1'b1;
                    r_d.state = swu_pkg::ST_DONE;
                end
            end
            swu_pkg::ST_DONE: begin
                // status holds; next command restarts
                r_d.state = swu_pkg::ST_IDLE;
            end
            default: begin
                r_d.state = swu_pkg::ST_IDLE;
            end
        endcase
        // synchronous reset wins over every transition above
        if (sys_rst) begin
            r_d = '0;
            r_d.stat_q = swu_pkg::STATUS_RST;
            r_d.err_q  = swu_pkg::ERROR_RST;
            r_d.state  = swu_pkg::ST_IDLE;
        end
    end

    // single register stage, synchronous reset folded in above
    always_ff @(posedge clk) begin
        r_q <= r_d;
    end

    // media request, stream selection and urgency
    always_comb begin
        stream_sel        = r_q.feat[swu_pkg::FB_STREAM_HI:swu_pkg::FB_STREAM_LO];
        media_valid       = (r_q.state == swu_pkg::ST_XFER) && !expired;
        media_req.lba     = r_q.lba;
        media_req.stream  = stream_sel;
        media_req.urgent  = r_q.feat[swu_pkg::FB_URGENT];
        flush_req         = (r_q.state == swu_pkg::ST_FLUSH);
    end

    // mark store: command marks, host writes clear marks except in ST_MARK, where the command request wins
    always_comb begin
        mark_valid       = (r_q.state == swu_pkg::ST_MARK) || host_write;
        mark.clear       = (r_q.state != swu_pkg::ST_MARK);
        mark.lba         = (r_q.state == swu_pkg::ST_MARK) ? r_q.lba : host_write_lba;
        mark.whole_block = (r_q.feat[7:4] == swu_pkg::MU_PSEUDO);
        mark.logged      = (r_q.feat[3:0] == swu_pkg::MU_LOG);
        if (r_q.state == swu_pkg::ST_MARK && r_q.feat[7:4] == swu_pkg::MU_FLAGGED) begin
            mark.whole_block = 1'b0;
        end
    end

    // readback of failing address, low or high halves by select
    always_comb begin
        lba_low_rd  = hob ? r_q.fail_lba[31:24] : r_q.fail_lba[7:0];
        lba_mid_rd  = hob ? r_q.fail_lba[39:32] : r_q.fail_lba[15:8];
        lba_high_rd = hob ? r_q.fail_lba[47:40] : r_q.fail_lba[23:16];
    end

    assign error_flags       = r_q.err_q;
    assign completion_status = r_q.stat_q;
    assign done_irq          = r_q.irq;

endmodule

// >>> verilog/swu_pkg.sv
/*
 * package for the stream write / mark-uncorrectable command handler:
 * opcodes, feature field positions, status and error bit positions,
 * timing counts and the carrier structs shared with the surroundings.
 * assumes a 250 MHz clock; US_CYCLES is derived from it, the 50 ms floor is not.
 */
package swu_pkg;

    localparam int unsigned CLK_MHZ          = 250;          // core clock rate
    localparam logic [7:0]  OP_STREAM_WRITE  = 8'h3b;        // streaming pio write
    localparam logic [7:0]  OP_MARK_UNC      = 8'h45;        // mark sectors uncorrectable
    // feature byte fields of the stream write
    localparam int unsigned FB_URGENT        = 7;
    localparam int unsigned FB_CONT_ERR      = 6;
    localparam int unsigned FB_FLUSH         = 5;
    localparam int unsigned FB_RESUME        = 4;
    localparam int unsigned FB_STREAM_HI     = 2;
    localparam int unsigned FB_STREAM_LO     = 0;
    // mark-uncorrectable feature nibbles
    localparam logic [3:0]  MU_PSEUDO        = 4'h5;
    localparam logic [3:0]  MU_FLAGGED       = 4'ha;
    localparam logic [3:0]  MU_LOG           = 4'h5;
    localparam logic [3:0]  MU_NOLOG         = 4'ha;
    localparam int unsigned DEVHEAD_LBA      = 6;
    // error_flags bit positions
    localparam int unsigned ER_UNC           = 6;
    localparam int unsigned ER_ID_NOT_FOUND          = 4;
    localparam int unsigned ER_ABORT         = 2;
    localparam int unsigned ER_TLO           = 0;
    // completion_status bit positions
    localparam int unsigned ST_BUSY          = 7;
    localparam int unsigned ST_READY         = 6;
    localparam int unsigned ST_STREAM_ERR    = 5;
    localparam int unsigned ST_ERR           = 0;
    localparam logic [7:0]  STATUS_RST       = 8'h40;        // ready, idle
    localparam logic [7:0]  ERROR_RST        = 8'h00;
    // time limit: one microsecond tick, 50 ms floor
    localparam int unsigned US_CYCLES        = CLK_MHZ;      // 1 us at clock rate
    localparam int unsigned LIMIT_FLOOR_MS   = 50;
    localparam logic [39:0] LIMIT_FLOOR_US   = 40'(LIMIT_FLOOR_MS * 1000);
    localparam int unsigned STREAMS          = 8;

    // task file as written by the host (current and previous bytes)
    typedef struct packed {
        logic [7:0]  feat_cur;
        logic [7:0]  feat_prev;
        logic [15:0] count;
        logic [47:0] lba;
        logic [7:0]  dev_head;
        logic [7:0]  opcode;
    } swu_taskfile_s;

    // one sector request to the media engine
    typedef struct packed {
        logic [47:0] lba;
        logic [2:0]  stream;
        logic        urgent;
    } swu_media_req_s;

    // marking request to the nonvolatile defect store
    typedef struct packed {
        logic [47:0] lba;
        logic        whole_block;   // pseudo: whole physical block
        logic        logged;        // failed reads go to error logs
        logic        clear;         // a write repairs the sector
    } swu_mark_s;

    typedef enum logic [2:0] {
        ST_IDLE, ST_XFER, ST_FLUSH, ST_MARK, ST_DONE
    } swu_state_e;

endpackage

// >>> verification/swu_far_model.sv
/* far-side model: media engine, flush path and nonvolatile mark store.
   assumes it sees the command strobe to restart its per-command counters. */
`timescale 1ns/1ps
module swu_far_model (
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    input  wire logic                    cmd_valid,
    input  wire logic                    media_valid,
    input  wire swu_pkg::swu_media_req_s media_req,
    output logic                         media_ready,
    output logic                         media_err,
    output logic                         media_err_id_not_found,
    input  wire logic                    flush_req,
    output logic                         flush_done,
    input  wire logic                    mark_valid,
    input  wire swu_pkg::swu_mark_s      mark,
    output logic                         mark_ready,
    output logic                         mark_fail,
    input  wire logic                    stall,      // answer every other cycle
    input  wire logic [31:0]             err_at,     // failing sector index
    input  wire logic                    err_id_not_found,   // failure kind
    input  wire logic                    fail_mark,  // store refuses
    output logic [31:0]                  sectors,    // sectors taken
    output swu_pkg::swu_media_req_s      first_req,
    output swu_pkg::swu_media_req_s      last_req,
    output logic                         flushed,
    output swu_pkg::swu_mark_s           last_mark
);
    logic       tgl;        // flips each cycle, fills unqualified lines
    logic [2:0] flush_cnt;  // flush takes a few cycles
    // errors reported yet every sector still taken
    assign media_ready    = media_valid & ~(stall & tgl);
    assign media_err      = media_ready ? (sectors == err_at) : tgl;
    assign media_err_id_not_found = media_ready ? err_id_not_found : ~tgl;
    assign flush_done     = flush_req & (flush_cnt == 3'h5);
    assign mark_ready     = mark_valid;
    // stored marks kept
    assign mark_fail      = mark_ready ? fail_mark : tgl;
    // counters restart with each command
    always @(posedge clk) begin
        tgl <= sys_rst ? 1'b0 : ~tgl;
        flush_cnt <= flush_req ? flush_cnt + 3'h1 : 3'h0;
        if (sys_rst || cmd_valid) begin
            sectors <= 32'h0;
            flushed <= 1'b0;
        end else begin
            if (media_ready) begin
                sectors <= sectors + 32'h1;
                last_req <= media_req;
                if (sectors == 32'h0) first_req <= media_req;
            end
            if (flush_done) flushed <= 1'b1;
        end
        if (mark_valid && mark_ready) last_mark <= mark;
    end
endmodule

// >>> verification/swu_cmd_assertions.sv
/* port-level checker for swu_cmd: status, pulse and handshake relations.
   assumes only the top ports; bound at the foot of this file. */
`timescale 1ns/1ps
module swu_cmd_assertions (
    input wire logic                    clk,
    input wire logic                    sys_rst,
    input wire logic                    cmd_valid,
    input wire logic                    flush_req,
    input wire logic                    flush_done,
    input wire logic                    media_valid,
    input wire swu_pkg::swu_media_req_s media_req,
    input wire logic [2:0]              stream_sel,
    input wire logic                    mark_valid,
    input wire swu_pkg::swu_mark_s      mark,
    input wire logic                    host_write,
    input wire logic [47:0]             host_write_lba,
    input wire logic [7:0]              error_flags,
    input wire logic [7:0]              completion_status,
    input wire logic                    done_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic idle;  // not busy and not the completion cycle
    assign idle = !completion_status[7] && !done_irq;
    a_cmd_taken: assert property (idle && cmd_valid |=> completion_status[7] || done_irq)
        else $error("command not taken");
    a_irq_pulse: assert property ($rose(done_irq) |=> !done_irq [*2])
        else $error("completion pulse too long");
    a_done_idle: assert property (done_irq |-> !completion_status[7])
        else $error("busy at completion");
    a_se_no_err: assert property (done_irq && completion_status[5] |-> !completion_status[0])
        else $error("stream error with err");
    a_tlo_se: assert property (done_irq && error_flags[0] |-> completion_status[5])
        else $error("time limit without stream error");
    a_xfer_busy: assert property (media_valid |-> completion_status[7])
        else $error("transfer while idle");
    a_req_stream: assert property (media_valid |-> media_req.stream == stream_sel)
        else $error("request stream mismatch");
    // only a time limit expiry may end the command before the flush is done
    a_flush_hold: assert property (flush_req && !flush_done |=> flush_req || (done_irq && error_flags[0]))
        else $error("completion before flush");
    a_write_repair: assert property (host_write |-> mark_valid && mark.clear && mark.lba == host_write_lba)
        else $error("host write not forwarded");
    a_mark_busy: assert property (mark_valid && !host_write |-> completion_status[7] && !mark.clear)
        else $error("mark request while idle");
    c_stream_err: cover property (done_irq && completion_status[5]);
    c_flush: cover property (flush_req && flush_done);
    c_pseudo: cover property (mark_valid && mark.whole_block && !host_write);
endmodule
bind swu_cmd swu_cmd_assertions i_swu_cmd_assertions (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .flush_req(flush_req), .flush_done(flush_done), .media_valid(media_valid), .media_req(media_req),
    .stream_sel(stream_sel), .mark_valid(mark_valid), .mark(mark), .host_write(host_write),
    .host_write_lba(host_write_lba), .error_flags(error_flags), .completion_status(completion_status),
    .done_irq(done_irq));

// >>> verification/swu_cmd_test.sv
/* self-checking bench for swu_cmd with the far-side model.
   assumes a 4 ns clock; US_CYCLES is 1, so the 50 ms floor is 50000 cycles. */
`timescale 1ns/1ps
module swu_cmd_test;
    logic clk = 1'b0, sys_rst = 1'b1, cmd_valid = 1'b0, hob = 1'b0, host_write = 1'b0;
    logic stall = 1'b0, err_id_not_found = 1'b0, fail_mark = 1'b0, stream_defined = 1'b0;
    logic [31:0] time_unit_us = 32'h1, err_at = 32'hffffffff, sectors;
    logic [47:0] stream_err_lba = 48'h0, host_write_lba = 48'h0, lba;
    swu_pkg::swu_taskfile_s  tf = '0;
    swu_pkg::swu_media_req_s media_req, first_req, last_req;
    swu_pkg::swu_mark_s      mark, last_mark;
    logic [2:0]  stream_sel, sel;
    logic [7:0]  error_flags, completion_status, lba_low_rd, lba_mid_rd, lba_high_rd;
    logic        media_valid, media_ready, media_err, media_err_id_not_found, flush_req, flush_done;
    logic        mark_valid, mark_ready, mark_fail, done_irq, flushed;
    int          fails = 0;
    int          check_count = 0;
    logic [15:0] notes[$];  // expected {status, error}, oldest first
    logic [7:0]  feats[4] = '{8'h55, 8'h5a, 8'ha5, 8'haa};
    // short microsecond keeps the floor test under the run budget
    swu_cmd #(.US_CYCLES(1)) i_swu_cmd (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .taskfile(tf),
        .hob(hob), .time_unit_us(time_unit_us), .stream_default(8'h00), .stream_defined(stream_defined),
        .stream_err_lba(stream_err_lba), .stream_sel(stream_sel), .media_valid(media_valid),
        .media_req(media_req), .media_ready(media_ready), .media_err(media_err),
        .media_err_id_not_found(media_err_id_not_found), .flush_req(flush_req), .flush_done(flush_done),
        .mark_valid(mark_valid), .mark(mark), .mark_ready(mark_ready), .mark_fail(mark_fail),
        .host_write(host_write), .host_write_lba(host_write_lba), .error_flags(error_flags),
        .completion_status(completion_status), .lba_low_rd(lba_low_rd), .lba_mid_rd(lba_mid_rd),
        .lba_high_rd(lba_high_rd), .done_irq(done_irq));
    swu_far_model i_swu_far_model (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
        .media_valid(media_valid), .media_req(media_req), .media_ready(media_ready), .media_err(media_err),
        .media_err_id_not_found(media_err_id_not_found), .flush_req(flush_req), .flush_done(flush_done),
        .mark_valid(mark_valid), .mark(mark), .mark_ready(mark_ready), .mark_fail(mark_fail),
        .stall(stall), .err_at(err_at), .err_id_not_found(err_id_not_found), .fail_mark(fail_mark), .sectors(sectors),
        .first_req(first_req), .last_req(last_req), .flushed(flushed), .last_mark(last_mark));
    always #2 clk = ~clk;
    task conclude;
        $display("comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task compare(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // completion watcher: oldest note against the ending registers
    always @(negedge clk) begin
        if (done_irq === 1'b1) begin
            if (notes.size() == 0) compare({completion_status, error_flags}, 64'hffff);
            else compare({completion_status, error_flags}, notes.pop_front());
        end
    end
    // one command, waits for completion plus the two-cycle gap
    task issue(input logic [7:0] op, fc, fp, input logic [15:0] cnt, input logic [47:0] a,
               input logic [7:0] dh, input logic [15:0] exp);
        int n;
        notes.push_back(exp);
        @(negedge clk);
        tf = '{fc, fp, cnt, a, dh, op};
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
        n = 0;
        while (done_irq !== 1'b1 && n < 70000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 70000) begin
            fails++;
            conclude();
        end
        repeat (2) @(negedge clk);
    endtask
    // failing address read back in low then high halves
    task readback(input logic [47:0] exp);
        // select changes on the falling edge, halves read one cycle later
        hob = 1'b0;
        @(negedge clk);
        compare({lba_high_rd, lba_mid_rd, lba_low_rd}, exp[23:0]);
        hob = 1'b1;
        @(negedge clk);
        compare({lba_high_rd, lba_mid_rd, lba_low_rd}, exp[47:24]);
        hob = 1'b0;
    endtask
    // hang guard, well past the floor test
    initial begin
        #360000;
        fails++;
        conclude();
    end
    initial begin
        void'($urandom(32'h250d));
        repeat (12) @(negedge clk);
        sys_rst = 1'b0;
        compare({completion_status, error_flags}, {swu_pkg::STATUS_RST, swu_pkg::ERROR_RST});
        lba = 48'({$urandom(), $urandom()});
        sel = 3'($urandom());
        stream_defined = 1'b1;  // defined stream with zero default: no limit
        issue(8'h3b, {5'h10, sel}, 8'h00, 16'h0003, lba, 8'h40, 16'h4000);
        compare(first_req, {lba, sel, 1'b1});
        compare(last_req.lba, lba + 48'h2);
        compare(stream_sel, sel);
        err_at = 32'h1;
        err_id_not_found = 1'b1;
        issue(8'h3b, 8'h40, 8'h00, 16'h0004, lba, 8'h40, 16'h6010);
        compare(sectors, 32'h4);
        readback(lba + 48'h1);
        err_at = 32'h0;
        err_id_not_found = 1'b0;
        issue(8'h3b, 8'h00, 8'h00, 16'h0002, lba, 8'h40, 16'h4104);
        compare(sectors, 32'h2);
        err_at = 32'hffffffff;
        stall = 1'b1;  // slow media plus flush
        issue(8'h3b, 8'h20, 8'h00, 16'h0002, lba, 8'h40, 16'h4000);
        compare(flushed, 1'b1);
        stall = 1'b0;
        stream_err_lba = 48'({$urandom(), $urandom()});
        issue(8'h3b, 8'h10, 8'h00, 16'h0001, lba, 8'h40, 16'h4000);
        compare(first_req.lba, stream_err_lba);
        foreach (feats[i]) begin
            issue(8'h45, feats[i], 8'h00, 16'h0001, lba, 8'h40, 16'h4000);
            compare({last_mark, 13'h0}, {lba, feats[i][7:4] == 4'h5, feats[i][3:0] == 4'h5, 14'h0});
        end
        issue(8'h45, 8'h33, 8'h00, 16'h0001, lba, 8'h40, 16'h4104);
        issue(8'h45, 8'h55, 8'h00, 16'h0001, lba, 8'h00, 16'h4104);
        fail_mark = 1'b1;
        issue(8'h45, 8'ha5, 8'h00, 16'h0001, lba, 8'h40, 16'h4104);
        fail_mark = 1'b0;
        host_write_lba = lba + 48'h7;
        host_write = 1'b1;
        @(negedge clk);
        host_write = 1'b0;
        compare({last_mark.lba, last_mark.clear}, {host_write_lba, 1'b1});
        // 1 us requested, floor raises it; count zero outlasts the limit
        issue(8'h3b, 8'h40, 8'h01, 16'h0000, lba, 8'h40, 16'h6001);
        compare(sectors >= 32'h0000c346 && sectors <= 32'h0000c35a, 1'b1);
        conclude();
    end
endmodule
